//--- rtl/hbd_top.sv
// Purpose: off-state and on-state diagnosis for four half bridges
// Assumes: analog comparators deliver raw levels asynchronously
// Notes:   reads of a diagnosis register reload it from live state
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module hbd_top #(
  parameter int ACT_CYCLES  = hbd_pkg::ACT_CYCLES,
  parameter int FILT_CYCLES = hbd_pkg::FILT_CYCLES
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  // direct drive pins
  input  wire logic [3:0]        direct_drive_inputs,
  // output stage feedback
  input  wire logic [3:0]        chan_overcurrent_flag,
  input  wire logic              bridge_pair1_overtemp_flag,
  input  wire logic              bridge_pair2_overtemp_flag,
  input  wire logic [3:0]        det_open_load,
  input  wire logic [3:0]        det_short_bat,
  input  wire logic [3:0]        short_to_ground,
  // switch drive
  output logic [3:0]             hs_on,
  output logic [3:0]             ls_on
);
  hbd_pkg::hbd_bus_t   bus;
  logic [9:0]          config_reg;
  logic [3:0]          output_control_reg;
  logic [3:0]          output_enable_config_reg;
  logic [3:0]          drv_s1;
  logic [3:0]          drv_s2;
  logic [15:0]         raw_s1;
  logic [15:0]         raw_s2;
  logic [5:0]          bridge_diag_reg_on_state;
  logic [7:0]          bridge_diag_reg_off_state;
  logic [7:0]          chan_off_diag_code;
  logic [3:0]          both_off;
  logic [3:0]          armed;
  logic [3:0]          chan_on;
  logic [3:0]          next_hs;
  logic [3:0]          next_ls;
  hbd_pkg::hbd_sense_t sense  [hbd_pkg::NUM_CH];
  hbd_pkg::hbd_sense_t stable [hbd_pkg::NUM_CH];

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for every pin-level input except the two overtemp flags
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drv_s1 <= 4'h0;
      drv_s2 <= 4'h0;
      raw_s1 <= 16'h0000;
      raw_s2 <= 16'h0000;
    end else begin
      drv_s1 <= direct_drive_inputs;
      drv_s2 <= drv_s1;
      raw_s1 <= {det_open_load, det_short_bat, short_to_ground, chan_overcurrent_flag};
      raw_s2 <= raw_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software writable configuration
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_reg               <= hbd_pkg::CONFIG_RST;
      output_control_reg       <= 4'h0;
      output_enable_config_reg <= 4'h0;
    end else if (bus.wr) begin
      case (bus.addr)
        hbd_pkg::ADDR_CONFIG:  config_reg               <= bus.wdata[9:0];
        hbd_pkg::ADDR_CONTROL: output_control_reg       <= bus.wdata[3:0];
        hbd_pkg::ADDR_ENABLE:  output_enable_config_reg <= bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switch decode per mode, freewheel, enable and on command
  always_comb begin
    chan_on = output_control_reg | drv_s2;
    for (int i = 0; i < hbd_pkg::NUM_CH; i++) begin
      logic hs;
      logic fw;
      hs = config_reg[hbd_pkg::MODE_LSB + i];
      fw = config_reg[hbd_pkg::FW_LSB + i];
      next_hs[i] = 1'b0;
      next_ls[i] = 1'b0;
      if (output_enable_config_reg[i]) begin
        // active freewheel keeps the opposite switch on while off,
        // so diagnosis only starts when the channel is disabled
        if (chan_on[i]) begin
          next_hs[i] = hs;
          next_ls[i] = !hs;
        end else begin
          next_hs[i] = fw && !hs;
          next_ls[i] = fw && hs;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hs_on <= 4'h0;
      ls_on <= 4'h0;
    end else begin
      hs_on <= next_hs;
      ls_on <= next_ls;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel timing; full bridge waits for both halves
  always_comb begin
    for (int i = 0; i < hbd_pkg::NUM_CH; i++) begin
      both_off[i] = !hs_on[i] && !ls_on[i];
    end
    if (config_reg[hbd_pkg::FB1_BIT]) begin
      both_off[1:0] = {2{&both_off[1:0]}};
    end
    if (config_reg[hbd_pkg::FB2_BIT]) begin
      both_off[3:2] = {2{&both_off[3:2]}};
    end
  end

  for (genvar g = 0; g < hbd_pkg::NUM_CH; g++) begin : g_ch
    assign sense[g] = '{open_load: raw_s2[12+g], short_bat: raw_s2[8+g],
                        short_gnd: raw_s2[4+g]};
    hbd_chan_timer #(
      .ACT_CYCLES  (ACT_CYCLES),
      .FILT_CYCLES (FILT_CYCLES)
    ) u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .both_off (both_off[g]),
      .sense    (sense[g]),
      .armed    (armed[g]),
      .stable   (stable[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // encoding, pairs are channel 0/1 and 2/3
  hbd_encode u_enc_a (
    .fb_en     (config_reg[hbd_pkg::FB1_BIT]),
    .high_side (config_reg[hbd_pkg::MODE_LSB +: 2]),
    .valid     (armed[1:0]),
    .sense_a   (stable[0]),
    .sense_b   (stable[1]),
    .code_a    (chan_off_diag_code[1:0]),
    .code_b    (chan_off_diag_code[3:2])
  );
  hbd_encode u_enc_b (
    .fb_en     (config_reg[hbd_pkg::FB2_BIT]),
    .high_side (config_reg[hbd_pkg::MODE_LSB + 2 +: 2]),
    .valid     (armed[3:2]),
    .sense_a   (stable[2]),
    .sense_b   (stable[3]),
    .code_a    (chan_off_diag_code[5:4]),
    .code_b    (chan_off_diag_code[7:6])
  );

  ////////////////////////////////////////////////////////////////////////
  // stored diagnosis: latched flags, refreshed on each read
  // every read returns the codes latched before it, which may be stale; software reads twice
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bridge_diag_reg_on_state <= 6'h00;
    end else if (bus.rd && bus.addr == hbd_pkg::ADDR_ON_DIAG) begin
      bridge_diag_reg_on_state <= {bridge_pair2_overtemp_flag, bridge_pair1_overtemp_flag,
                                   raw_s2[3:0]};
    end else begin
      bridge_diag_reg_on_state[hbd_pkg::OC_LSB +: 4] <=
        bridge_diag_reg_on_state[hbd_pkg::OC_LSB +: 4] | raw_s2[3:0];
      bridge_diag_reg_on_state[hbd_pkg::OT1_BIT] <=
        bridge_diag_reg_on_state[hbd_pkg::OT1_BIT] | bridge_pair1_overtemp_flag;
      bridge_diag_reg_on_state[hbd_pkg::OT2_BIT] <=
        bridge_diag_reg_on_state[hbd_pkg::OT2_BIT] | bridge_pair2_overtemp_flag;
    end
  end

  // capture only from armed channels; codes persist until read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bridge_diag_reg_off_state <= 8'h00;
    end else if (bus.rd && bus.addr == hbd_pkg::ADDR_OFF_DIAG) begin
      bridge_diag_reg_off_state <= chan_off_diag_code;
    end else begin
      for (int i = 0; i < hbd_pkg::NUM_CH; i++) begin
        if (armed[i] && chan_off_diag_code[2*i +: 2] != hbd_pkg::CODE_NONE) begin
          bridge_diag_reg_off_state[2*i +: 2] <= chan_off_diag_code[2*i +: 2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data: the old content is returned, refresh takes effect after
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        hbd_pkg::ADDR_ON_DIAG:  reg_rdata <= {10'h000, bridge_diag_reg_on_state};
        hbd_pkg::ADDR_OFF_DIAG: reg_rdata <= {8'h00, bridge_diag_reg_off_state};
        hbd_pkg::ADDR_CONFIG:   reg_rdata <= {6'h00, config_reg};
        hbd_pkg::ADDR_CONTROL:  reg_rdata <= {12'h000, output_control_reg};
        hbd_pkg::ADDR_ENABLE:   reg_rdata <= {12'h000, output_enable_config_reg};
        default:                reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

//--- rtl/hbd_pkg.sv
// Purpose: shared constants and types for the half-bridge diagnosis block
// Assumes: core_clk at 200 MHz
// Notes:   register indices and bit layout are local choices
package hbd_pkg;
  localparam int NUM_CH       = 4;
  localparam int CLK_MHZ      = 200;
  // activation: 60..135 us, pick minimum rounded up
  localparam int ACT_TIME_US  = 60;
  localparam int ACT_CYCLES   = ACT_TIME_US * CLK_MHZ;
  // filter: 0.5..2 us, pick 1 us (inside window)
  localparam int FILT_TIME_NS = 1000;
  localparam int FILT_CYCLES  = (FILT_TIME_NS * CLK_MHZ + 999) / 1000;

  localparam logic [3:0] ADDR_ON_DIAG  = 4'h0;
  localparam logic [3:0] ADDR_OFF_DIAG = 4'h1;
  localparam logic [3:0] ADDR_CONFIG   = 4'h2;
  localparam logic [3:0] ADDR_CONTROL  = 4'h3;
  localparam logic [3:0] ADDR_ENABLE   = 4'h4;

  // on-state register: [3:0] over-current, [4] pair1 ot, [5] pair2 ot
  localparam int OC_LSB  = 0;
  localparam int OT1_BIT = 4;
  localparam int OT2_BIT = 5;
  // config register: [3:0] high-side mode, [7:4] active freewheel, [8] fb1, [9] fb2
  localparam int MODE_LSB = 0;
  localparam int FW_LSB   = 4;
  localparam int FB1_BIT  = 8;
  localparam int FB2_BIT  = 9;

  localparam logic [1:0] CODE_NONE    = 2'h0;
  localparam logic [1:0] CODE_OPEN_HS = 2'h1;
  localparam logic [1:0] CODE_OPEN_LS = 2'h2;
  localparam logic [1:0] CODE_SHORT   = 2'h3;
  localparam logic [9:0] CONFIG_RST   = 10'h000;

  typedef struct packed {
    logic open_load;
    logic short_bat;
    logic short_gnd;
  } hbd_sense_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } hbd_bus_t;
endpackage

//--- rtl/hbd_chan_timer.sv
// Purpose: per-channel activation timer plus disturbance filter
// Assumes: sense inputs already synchronised
// Notes:   restarts whenever the channel leaves both-off
`timescale 1ns/1ps
module hbd_chan_timer #(
  parameter int ACT_CYCLES  = hbd_pkg::ACT_CYCLES,
  parameter int FILT_CYCLES = hbd_pkg::FILT_CYCLES
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // channel state
  input  wire logic              both_off,
  input  wire hbd_pkg::hbd_sense_t sense,
  // results
  output logic                   armed,
  output hbd_pkg::hbd_sense_t    stable
);
  logic [$clog2(ACT_CYCLES+1)-1:0]  act_cnt;
  logic [$clog2(FILT_CYCLES+1)-1:0] filt_cnt;
  hbd_pkg::hbd_sense_t              last;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_n || !both_off) begin
      act_cnt <= '0;
      armed   <= 1'b0;
    end else if (act_cnt == ($bits(act_cnt))'(ACT_CYCLES)) begin
      armed <= 1'b1;
    end else begin
      act_cnt <= act_cnt + 1'b1;
    end
  end

  // a sense change restarts the filter so glitches of up to FILT_CYCLES+1 cycles never reach stable
  always_ff @(posedge core_clk) begin
    if (!rst_n || !both_off) begin
      filt_cnt <= '0;
      last     <= '0;
      stable   <= '0;
    end else begin
      last <= sense;
      if (sense != last) begin
        filt_cnt <= '0;
      end else if (filt_cnt == ($bits(filt_cnt))'(FILT_CYCLES)) begin
        stable <= last;
      end else begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end
endmodule

//--- rtl/hbd_encode.sv
// Purpose: priority and full-bridge encoding of one bridge pair
// Assumes: inputs are filtered detection results
// Notes:   purely combinational
`timescale 1ns/1ps
module hbd_encode (
  // pair configuration
  input  wire logic                fb_en,
  input  wire logic [1:0]          high_side,
  // detection results, index 0 is first output
  input  wire logic [1:0]          valid,
  input  wire hbd_pkg::hbd_sense_t sense_a,
  input  wire hbd_pkg::hbd_sense_t sense_b,
  // codes
  output logic [1:0]               code_a,
  output logic [1:0]               code_b
);
  function automatic logic [1:0] single(input logic hs, input hbd_pkg::hbd_sense_t s);
    logic [1:0] c;
    c = hbd_pkg::CODE_NONE;
    if (hs ? s.short_bat : s.short_gnd) begin
      c = hbd_pkg::CODE_SHORT;
    end else if (s.open_load) begin
      c = hs ? hbd_pkg::CODE_OPEN_HS : hbd_pkg::CODE_OPEN_LS;
    end
    return c;
  endfunction

  always_comb begin
    code_a = hbd_pkg::CODE_NONE;
    code_b = hbd_pkg::CODE_NONE;
    if (!fb_en) begin
      if (valid[0]) code_a = single(high_side[0], sense_a);
      if (valid[1]) code_b = single(high_side[1], sense_b);
    end else if (&valid) begin
      // full bridge: double faults first, then single ones; 11 never produced
      if (sense_a.short_bat && (sense_b.short_gnd || sense_b.open_load)) begin
        code_a = 2'h2;
        code_b = 2'h1;
      end else if (sense_a.short_gnd && sense_b.short_bat) begin
        code_a = 2'h1;
        code_b = 2'h2;
      end else if (sense_a.open_load && sense_b.short_bat) begin
        code_b = 2'h2;
      end else if (sense_a.short_bat || sense_b.short_bat) begin
        code_a = 2'h2;
        code_b = 2'h2;
      end else if (sense_a.short_gnd) begin
        code_a = 2'h1;
        code_b = 2'h1;
      end else if (sense_a.open_load || sense_b.open_load || sense_b.short_gnd) begin
        code_b = 2'h1;
      end
    end
  end
endmodule

//--- verification/hbd_chk.sv
// Purpose: port-level assertions for the half-bridge diagnosis block
// Assumes: index map and bit layout of hbd_pkg
// Notes:   shadows config writes to know the channel setup
`timescale 1ns/1ps
module hbd_chk #(
  parameter int ACT_CYCLES = 20
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // stage feedback and drive
  input wire logic [3:0]  chan_overcurrent_flag,
  input wire logic        bridge_pair1_overtemp_flag,
  input wire logic [3:0]  hs_on,
  input wire logic [3:0]  ls_on
);
  logic [9:0] cfg;
  int         off_cnt;
  logic       rd_on;
  logic       rd_off;
  assign rd_on  = reg_rd && reg_addr == hbd_pkg::ADDR_ON_DIAG;
  assign rd_off = reg_rd && reg_addr == hbd_pkg::ADDR_OFF_DIAG;
  ////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg <= 10'h000;
    end else if (reg_wr && reg_addr == hbd_pkg::ADDR_CONFIG) begin
      cfg <= reg_wdata[9:0];
    end
  end
  // counted from the hs_on/ls_on outputs that also feed the internal timer, so it never lags it
  always_ff @(posedge core_clk) begin
    if (!rst_n || hs_on[0] || ls_on[0]) begin
      off_cnt <= 0;
    end else if (off_cnt < ACT_CYCLES) begin
      off_cnt <= off_cnt + 1;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  chk_unmapped_zero: assert property ((reg_rd && reg_addr > 4'h4) |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  chk_cfg_readback: assert property ((reg_wr && reg_addr == 4'h2) ##1 !reg_wr
    ##1 (reg_rd && reg_addr == 4'h2) |=> reg_rdata[9:0] == $past(reg_wdata[9:0], 3))
    else $error("config readback differs");
  chk_ot_report: assert property ((bridge_pair1_overtemp_flag && rd_on) ##1 rd_on
    |=> reg_rdata[hbd_pkg::OT1_BIT]) else $error("overtemp flag missing");
  chk_oc_report: assert property ((chan_overcurrent_flag[0] [*4]) ##0 rd_on ##1 rd_on
    |=> reg_rdata[hbd_pkg::OC_LSB]) else $error("overcurrent flag missing");
  chk_fb_legal: assert property ((rd_off && cfg[hbd_pkg::FB1_BIT]) ##1 rd_off |=>
    reg_rdata[1:0] != 2'h3 && reg_rdata[3:2] != 2'h3
    && !(reg_rdata[3:2] == 2'h0 && reg_rdata[1:0] != 2'h0)) else $error("illegal pair code");
  chk_mode_code: assert property ((rd_off && !cfg[hbd_pkg::FB1_BIT]) ##1 rd_off |=>
    reg_rdata[1:0] != (cfg[0] ? 2'h2 : 2'h1)) else $error("open code of wrong mode");
  chk_wait_armed: assert property ((rd_off && off_cnt < ACT_CYCLES) ##1 rd_off |=>
    reg_rdata[1:0] == 2'h0) else $error("code before activation time");
  chk_disable_off: assert property ((reg_wr && reg_addr == 4'h4 && !reg_wdata[0])
    ##1 (!(reg_wr && reg_addr == 4'h4)) [*2] |-> !hs_on[0] && !ls_on[0])
    else $error("disabled channel still driven");
  cov_fb_read: cover property ((rd_off && cfg[hbd_pkg::FB1_BIT]) ##1 rd_off);
  cov_short: cover property (rd_off ##1 reg_rdata[1:0] == 2'h3);
  cov_oc: cover property (rd_on ##1 reg_rdata[hbd_pkg::OC_LSB]);
endmodule

//--- verification/hbd_load_model.sv
// Purpose: behavioural loads and comparators on the four outputs
// Assumes: fault per channel: 0 none, 1 open, 2 battery, 3 ground
// Notes:   off-state comparators read low while a switch drives; glitch still sets det_short_bat
`timescale 1ns/1ps
module hbd_load_model (
  // switch drive
  input  wire logic [3:0] hs_on,
  input  wire logic [3:0] ls_on,
  // injected faults and disturbances
  input  wire logic [7:0] fault,
  input  wire logic [3:0] glitch,
  // comparator levels
  output logic      [3:0] det_open_load,
  output logic      [3:0] det_short_bat,
  output logic      [3:0] short_to_ground,
  output logic      [3:0] chan_overcurrent_flag
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      det_open_load[i]   = !hs_on[i] && !ls_on[i] && fault[2*i +: 2] == 2'h1;
      det_short_bat[i]   = (!hs_on[i] && !ls_on[i] && fault[2*i +: 2] == 2'h2) || glitch[i];
      short_to_ground[i] = !hs_on[i] && !ls_on[i] && fault[2*i +: 2] == 2'h3;
      // a short only draws current through the switch pulling against it
      chan_overcurrent_flag[i] = (hs_on[i] && fault[2*i +: 2] == 2'h3)
                                 || (ls_on[i] && fault[2*i +: 2] == 2'h2);
    end
  end
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench for the half-bridge diagnosis block
// Assumes: shortened activation and filter counts
// Notes:   each diagnosis read is done twice, the second one checked
`timescale 1ns/1ps
module testbench;
  localparam int ACT  = 20;
  localparam int FILT = 3;
  localparam int WAIT = ACT + FILT + 12;
  logic        core_clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0]  direct_drive_inputs;
  logic [3:0]  oc;
  logic        ot1;
  logic        ot2;
  logic [3:0]  det_ol;
  logic [3:0]  det_sb;
  logic [3:0]  det_sg;
  logic [3:0]  hs_on;
  logic [3:0]  ls_on;
  logic [7:0]  fault;
  logic [3:0]  glitch;
  logic [15:0] d;
  logic [15:0] v;
  logic [3:0]  m;
  logic [7:0]  f;
  logic [3:0]  dd;
  int          fail_count;
  int          tests_run;
  int          cyc;
  logic [7:0]  fb_f [4] = '{8'h55, 8'haa, 8'hff, 8'heb};
  logic [7:0]  fb_c [4] = '{8'h44, 8'haa, 8'h55, 8'h69};

  hbd_top #(.ACT_CYCLES(ACT), .FILT_CYCLES(FILT)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .direct_drive_inputs(direct_drive_inputs), .chan_overcurrent_flag(oc),
    .bridge_pair1_overtemp_flag(ot1), .bridge_pair2_overtemp_flag(ot2),
    .det_open_load(det_ol), .det_short_bat(det_sb), .short_to_ground(det_sg),
    .hs_on(hs_on), .ls_on(ls_on));
  hbd_load_model u_load (.hs_on(hs_on), .ls_on(ls_on), .fault(fault), .glitch(glitch),
    .det_open_load(det_ol), .det_short_bat(det_sb), .short_to_ground(det_sg),
    .chan_overcurrent_flag(oc));
  ////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= x;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // two back-to-back reads; the first reloads, the second is returned
  task automatic rd2(input logic [3:0] a, output logic [15:0] x);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [1:0] drv(input logic md, fw, en, on);
    if (!en) return 2'b00;
    if (on) return md ? 2'b10 : 2'b01;
    if (fw) return md ? 2'b01 : 2'b10;
    return 2'b00;
  endfunction
  function automatic logic [15:0] single(input logic [3:0] md, input logic [7:0] fl);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      case (fl[2*k +: 2])
        2'h1: r[2*k +: 2] = md[k] ? 2'h1 : 2'h2;
        2'h2: r[2*k +: 2] = md[k] ? 2'h3 : 2'h0;
        2'h3: r[2*k +: 2] = md[k] ? 2'h0 : 2'h3;
        default: r[2*k +: 2] = 2'h0;
      endcase
    end
    return r;
  endfunction
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, direct_drive_inputs} = '0;
    {ot1, ot2, fault, glitch, fail_count, tests_run, cyc} = '0;
    void'($urandom(29662));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd2(hbd_pkg::ADDR_CONFIG, d);
    chk(d, 16'h0000);
    for (int a = 5; a < 16; a++) begin
      rd2(4'(a), d);
      chk(d, 16'h0000);
    end
    v = 16'($urandom_range(1023, 0));
    wr(hbd_pkg::ADDR_CONFIG, v);
    rd2(hbd_pkg::ADDR_CONFIG, d);
    chk(d, v);
    for (int i = 0; i < 16; i++) begin
      dd = 4'($urandom);
      wr(hbd_pkg::ADDR_CONFIG, {11'h0, i[1], 3'h0, i[0]});
      wr(hbd_pkg::ADDR_ENABLE, {15'h0, i[2]});
      wr(hbd_pkg::ADDR_CONTROL, {15'h0, i[3]});
      direct_drive_inputs <= dd;
      repeat (6) @(posedge core_clk);
      #1 chk({14'h0, hs_on[0], ls_on[0]}, {14'h0, drv(i[0], i[1], i[2], i[3] | dd[0])});
    end
    direct_drive_inputs <= 4'h0;
    wr(hbd_pkg::ADDR_ENABLE, 16'h0000);
    wr(hbd_pkg::ADDR_CONTROL, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 4'h5 : 4'($urandom);
      f = (i == 0) ? 8'hb4 : 8'($urandom);
      fault <= f;
      wr(hbd_pkg::ADDR_CONFIG, {12'h0, m});
      repeat (WAIT) @(posedge core_clk);
      rd2(hbd_pkg::ADDR_OFF_DIAG, d);
      chk(d, single(m, f));
    end
    wr(hbd_pkg::ADDR_CONFIG, 16'h0300);
    for (int j = 0; j < 4; j++) begin
      fault <= fb_f[j];
      repeat (WAIT) @(posedge core_clk);
      rd2(hbd_pkg::ADDR_OFF_DIAG, d);
      chk(d, {8'h0, fb_c[j]});
    end
    fault <= 8'haa;
    wr(hbd_pkg::ADDR_CONFIG, 16'h000f);
    repeat (WAIT) @(posedge core_clk);
    wr(hbd_pkg::ADDR_ENABLE, 16'h0001);
    wr(hbd_pkg::ADDR_CONTROL, 16'h0001);
    repeat (10) @(posedge core_clk);
    wr(hbd_pkg::ADDR_CONTROL, 16'h0000);
    repeat (8) @(posedge core_clk);
    rd2(hbd_pkg::ADDR_OFF_DIAG, d);
    chk(d, 16'h00fc);
    repeat (WAIT) @(posedge core_clk);
    rd2(hbd_pkg::ADDR_OFF_DIAG, d);
    chk(d, 16'h00ff);
    fault <= 8'h00;
    repeat (WAIT) @(posedge core_clk);
    glitch <= 4'h1;
    repeat (2) @(posedge core_clk);
    glitch <= 4'h0;
    repeat (12) @(posedge core_clk);
    rd2(hbd_pkg::ADDR_OFF_DIAG, d);
    chk(d, 16'h0000);
    glitch <= 4'h1;
    repeat (12) @(posedge core_clk);
    rd2(hbd_pkg::ADDR_OFF_DIAG, d);
    chk(d, 16'h0003);
    glitch <= 4'h0;
    fault <= 8'h02;
    ot1 <= 1'b1;
    ot2 <= 1'($urandom);
    wr(hbd_pkg::ADDR_CONFIG, 16'h0000);
    wr(hbd_pkg::ADDR_CONTROL, 16'h0001);
    repeat (8) @(posedge core_clk);
    rd2(hbd_pkg::ADDR_ON_DIAG, d);
    chk(d, {10'h0, ot2, 1'b1, 4'h1});
    wr(hbd_pkg::ADDR_CONTROL, 16'h0000);
    {ot1, ot2} <= 2'b00;
    repeat (8) @(posedge core_clk);
    rd2(hbd_pkg::ADDR_ON_DIAG, d);
    chk(d, 16'h0000);
    test_done();
  end
endmodule

bind hbd_top hbd_chk #(.ACT_CYCLES(ACT_CYCLES)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .chan_overcurrent_flag(chan_overcurrent_flag),
  .bridge_pair1_overtemp_flag(bridge_pair1_overtemp_flag), .hs_on(hs_on), .ls_on(ls_on));
